// ---- tb/mem_port_dispatch_properties.sv ----
// Port-level assertions for the memory access port dispatcher
`timescale 1ns/10ps
`default_nettype none

module mem_port_dispatch_properties #(
  parameter logic [7:0] PORT_NUMBER = 8'h00,
  parameter logic [31:0] IDENT_VALUE = 32'h0000_0000
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] port_select_field,
  input wire logic [3:0] register_bank_select,
  input wire logic [1:0] req_reg_index,
  input wire logic req_write,
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [31:0] resp_rdata,
  input wire logic resp_error,
  input wire logic abort,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic [31:0] mem_addr,
  input wire logic mem_write,
  input wire logic mem_barrier,
  input wire logic mem_resp_valid,
  input wire logic mem_resp_ready,
  input wire logic mem_resp_error
);
  logic [7:0] off;
  logic take, mine, plain, bad;
  assign off = {register_bank_select, req_reg_index, 2'b00};
  assign take = req_valid && req_ready;
  assign mine = take && port_select_field == PORT_NUMBER;
  assign plain = off == 8'h00 || off == 8'h04 || off >= 8'hf4;
  assign bad = mem_resp_valid && mem_resp_ready && mem_resp_error;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  plain_no_mem_a: assert property (mine && plain |=> resp_valid && !mem_req_valid)
    else $error("plain access began a beat");
  window_issue_a: assert property (
    mine && off == 8'h0c |=> mem_req_valid && mem_write == $past(req_write))
    else $error("window beat missing");
  bank_addr_a: assert property (
    mine && off[7:4] == 4'h1 |=> mem_req_valid && mem_addr[3:0] == {$past(req_reg_index), 2'b00})
    else $error("banked address wrong");
  barrier_a: assert property (mine && off == 8'h20 |=> mem_req_valid && mem_barrier)
    else $error("barrier beat missing");
  beat_hold_a: assert property (
    mem_req_valid && !mem_req_ready && !abort |=> mem_req_valid && $stable(mem_addr))
    else $error("beat changed while pending");
  error_answer_a: assert property (bad |-> ##[1:3] resp_valid && resp_error)
    else $error("error not reported");
  answer_hold_a: assert property (
    resp_valid && !resp_ready && !abort |=> resp_valid && $stable(resp_rdata))
    else $error("answer not held");
  wrong_port_a: assert property (
    take && !mine |=> resp_valid && resp_rdata == 32'h0 && !mem_req_valid)
    else $error("other port request served");
  ident_a: assert property (mine && off == 8'hfc && !req_write |=> resp_rdata == IDENT_VALUE)
    else $error("ident word wrong");
  abort_quiet_a: assert property (abort && !req_ready |=> !mem_req_valid && !resp_valid)
    else $error("busy after abort");

  cover property (mine && off[7:4] == 4'h1);
  cover property (bad);
  cover property (abort && !req_ready);
endmodule : mem_port_dispatch_properties

bind mem_port_dispatch mem_port_dispatch_properties #(
  .PORT_NUMBER(PORT_NUMBER), .IDENT_VALUE(IDENT_VALUE)) checks (.*);

`default_nettype wire

// ---- tb/mem_port_dispatch_test.sv ----
// Self-checking bench for the memory access port dispatcher
`timescale 1ns/10ps
`default_nettype none

module mem_port_dispatch_test
  import mem_port_pkg::*;
;
  localparam logic [31:0] ID = 32'h0a0b_0c0d; // Arbitrary value
  localparam logic [31:0] SCR = 32'h5a5a_5a5a;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, resp_ready = 1'b0, abort = 1'b0;
  logic [7:0] port_select_field = 8'h0;
  logic [3:0] register_bank_select = 4'h0;
  logic [1:0] req_reg_index = 2'h0;
  logic [31:0] req_wdata = 32'h0, err_addr = 32'hffff_ffff;
  logic [7:0] delay = 8'h0;
  logic req_ready, resp_valid, resp_error, mem_req_valid, mem_req_ready, mem_write;
  logic mem_barrier, mem_resp_valid, mem_resp_ready, mem_resp_error, er;
  logic [31:0] resp_rdata, mem_addr, mem_wdata, mem_wdata_hi, mem_resp_rdata;
  logic [31:0] mem_resp_rdata_hi, rd;
  logic [2:0] mem_size;
  int fails = 0;
  int num_checks = 0;
  typedef struct {
    logic [7:0] port;
    logic [7:0] off;
    logic wr;
    logic [31:0] wd;
    logic [31:0] rd;
    int beats;
    logic [31:0] addr;
  } row_t;
  row_t rows [14] = '{
    '{8'h00, 8'h04, 1'b1, 32'h1238, 32'h0, 0, 32'h0},
    '{8'h00, 8'h04, 1'b0, 32'h0, 32'h1238, 0, 32'h0},
    '{8'h00, 8'hfc, 1'b0, 32'h0, ID, 0, 32'h0},
    '{8'h00, 8'hfc, 1'b1, 32'hffff_ffff, 32'h0, 0, 32'h0},
    '{8'h00, 8'hfc, 1'b0, 32'h0, ID, 0, 32'h0},
    '{8'h00, 8'hf8, 1'b0, 32'h0, 32'hc000_0000, 0, 32'h0},
    '{8'h00, 8'h0c, 1'b1, 32'hcafe_f00d, 32'h0, 1, 32'h1238},
    '{8'h00, 8'h0c, 1'b0, 32'h0, 32'h1238 ^ SCR, 1, 32'h1238},
    '{8'h00, 8'h10, 1'b0, 32'h0, 32'h1230 ^ SCR, 1, 32'h1230},
    '{8'h00, 8'h14, 1'b0, 32'h0, 32'h1234 ^ SCR, 1, 32'h1234},
    '{8'h00, 8'h18, 1'b0, 32'h0, 32'h1238 ^ SCR, 1, 32'h1238},
    '{8'h00, 8'h1c, 1'b0, 32'h0, 32'h123c ^ SCR, 1, 32'h123c},
    '{8'h00, 8'h20, 1'b1, 32'h0, 32'h0, 1, 32'h1238},
    '{8'h01, 8'hfc, 1'b0, 32'h0, 32'h0, 0, 32'h0}
  };

  mem_port_dispatch #(.IDENT_VALUE(ID)) dut (.*);
  mem_responder mem (.*);

  always #12.5 clock = ~clock;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Start after a falling edge
  task automatic issue(input logic [7:0] port, input logic [7:0] off, input logic wr,
                       input logic [31:0] wd);
    int n = 0;
    port_select_field = port;
    register_bank_select = off[7:4];
    req_reg_index = off[3:2];
    req_write = wr;
    req_wdata = wd;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
  endtask : issue

  // Answer left waiting a cycle to test its holding
  task automatic access(input logic [7:0] port, input logic [7:0] off, input logic wr,
                        input logic [31:0] wd);
    int n = 0;
    issue(port, off, wr, wd);
    while (resp_valid !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    resp_ready = 1'b1;
    rd = resp_rdata;
    er = resp_error;
    @(negedge clock);
    resp_ready = 1'b0;
  endtask : access

  task automatic put(input logic [7:0] off, input logic [31:0] wd);
    access(8'h00, off, 1'b1, wd);
  endtask : put

  task automatic get(input logic [7:0] off);
    access(8'h00, off, 1'b0, 32'h0);
  endtask : get

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Run needs under 5000 cycles
  initial begin
    #500_000;
    fails++;
    complete_run();
  end

  initial begin
    int b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    get(OFF_CONTROL_STATUS);
    check("reset csw", 32'h2, rd & 32'h3f);
    get(OFF_TRANSFER_ADDR);
    check("reset address", 32'h0, rd);
    foreach (rows[i]) begin
      b0 = mem.beats;
      access(rows[i].port, rows[i].off, rows[i].wr, rows[i].wd);
      if (!rows[i].wr) check("read data", rows[i].rd, rd);
      check("beats", rows[i].beats, mem.beats - b0);
      if (rows[i].beats > 0) check("address", rows[i].addr, mem.seen[b0]);
    end
    // ----------------
    // Counted, packed, error, stall, abort
    // ----------------
    put(OFF_XFER_COUNT, 32'h2);
    put(OFF_CONTROL_STATUS, 32'h12);
    b0 = mem.beats;
    get(OFF_DATA_WINDOW);
    check("counted beats", 32'd3, mem.beats - b0);
    for (int k = 0; k < 3; k++) check("counted address", 32'h1238 + 4 * k, mem.seen[b0 + k]);
    put(OFF_XFER_COUNT, 32'h0);
    put(OFF_CONTROL_STATUS, 32'h20);
    put(OFF_TRANSFER_ADDR, 32'h2000);
    b0 = mem.beats;
    put(OFF_DATA_WINDOW, 32'h4433_2211);
    check("packed beats", 32'd4, mem.beats - b0);
    for (int k = 0; k < 4; k++) check("packed address", 32'h2000 + k, mem.seen[b0 + k]);
    put(OFF_CONTROL_STATUS, 32'h12);
    put(OFF_TRANSFER_ADDR, 32'h3000);
    put(OFF_XFER_COUNT, 32'h3);
    err_addr = 32'h3004;
    b0 = mem.beats;
    get(OFF_DATA_WINDOW);
    check("error flag", 32'h1, {31'h0, er});
    check("error beats", 32'd2, mem.beats - b0);
    err_addr = 32'hffff_ffff;
    put(OFF_XFER_COUNT, 32'h0);
    put(OFF_CONTROL_STATUS, 32'h2);
    put(OFF_TRANSFER_ADDR, 32'h4000);
    delay = 8'd40;
    get(OFF_DATA_WINDOW);
    check("slow read data", 32'h4000 ^ SCR, rd);
    issue(8'h00, OFF_DATA_WINDOW, 1'b0, 32'h0);
    repeat (3) @(negedge clock);
    abort = 1'b1;
    @(negedge clock);
    abort = 1'b0;
    b0 = 0;
    repeat (120) begin
      @(negedge clock);
      if (resp_valid !== 1'b0) b0++;
    end
    check("abort answers", 32'd0, b0);
    delay = 8'd0;
    get(OFF_TRANSFER_ADDR);
    check("address after abort", 32'h4000, rd);
    complete_run();
  end
endmodule : mem_port_dispatch_test

`default_nettype wire

// ---- tb/mem_responder.sv ----
// Memory side model: adjustable latency, one faulting address
`timescale 1ns/10ps
`default_nettype none

module mem_responder (
  input wire logic clock,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [31:0] mem_addr,
  input wire logic mem_resp_ready,
  output logic mem_resp_valid,
  output logic [31:0] mem_resp_rdata,
  output logic [31:0] mem_resp_rdata_hi,
  output logic mem_resp_error,
  input wire logic [7:0] delay,
  input wire logic [31:0] err_addr
);
  int beats = 0;
  logic [31:0] seen [$];
  logic [31:0] a;
  initial begin
    mem_req_ready = 1'b0;
    mem_resp_valid = 1'b0;
    mem_resp_error = 1'b0;
    mem_resp_rdata = 32'h0;
    mem_resp_rdata_hi = 32'h0;
    forever begin
      @(negedge clock);
      if (mem_req_valid === 1'b1) begin
        repeat (delay) @(negedge clock);
        if (mem_req_valid === 1'b1) begin
          a = mem_addr;
          seen.push_back(a);
          beats++;
          mem_req_ready = 1'b1;
          @(negedge clock);
          mem_req_ready = 1'b0;
          repeat (delay) @(negedge clock);
          mem_resp_valid = 1'b1;
          mem_resp_error = a === err_addr;
          mem_resp_rdata = a ^ 32'h5a5a_5a5a;
          mem_resp_rdata_hi = ~a;
          while (mem_resp_ready !== 1'b1) @(negedge clock);
          @(negedge clock);
          mem_resp_valid = 1'b0;
          mem_resp_error = 1'b0;
          // Released data toggles so stale values never look valid
          mem_resp_rdata = ~mem_resp_rdata;
          mem_resp_rdata_hi = ~mem_resp_rdata_hi;
        end
      end
    end
  end
endmodule : mem_responder

`default_nettype wire

// ---- verilog/mem_addr_former.sv ----
// Forms the memory address for window and banked data accesses
`timescale 1ns/10ps
`default_nettype none

module mem_addr_former (
  input wire logic [31:0] transfer_address,
  input wire logic banked,
  input wire logic [1:0] bank_index,
  output logic [31:0] mem_addr
);
  // Banked words ignore the transfer address low nibble
  always_comb begin
    if (banked) begin
      mem_addr = {transfer_address[31:4], bank_index, 2'b00}; // R04 R05 R06
    end else begin
      mem_addr = transfer_address; // R02 R03
    end
  end

endmodule : mem_addr_former

`default_nettype wire

// ---- verilog/mem_port_dispatch.sv ----
// Register front end of the debug memory access port
// Function
// [R01] Plain register accesses never start memory transactions
// [R02] Window write writes memory at transfer address
// [R03] Window read returns data after memory read
// [R04] Banked words hit four consecutive memory words
// [R05] Banked address ignores transfer address low nibble
// [R06] Bank index gives bits 3:2, bits 1:0 zero
// [R07] Barrier register access starts memory transaction
// [R08] Wide size: some data accesses skip memory
// [R09] Nonzero transaction counter repeats memory transactions
// [R10] Packed sub-word window access splits into beats
// [R11] Completion waits for all beats, error or abort
// [R12] Error ends request, drops remaining beats
// [R13] Debugger abort cancels pending memory activity
// [R14] Identification word answers at offset 0xfc
// [R15] Components occupy 4KB blocks of address space
// [R16] Several components need a directory table
// [R17] Component base aligned to 64KB granule
// [R18] Debugger skips unsupported register block types
// [R19] Base pointer names component or directory table
// [R20] Port select routes, bank select gives A[7:4]
// [R21] A[3:2] picks register, flag picks direction
// [R22] Request may stay pending without cycle bound
// [R23] Multiple beats issue in ascending order, one each; code repeats one address with increment off or on banked words
`timescale 1ns/10ps
`default_nettype none

module mem_port_dispatch
  import mem_port_pkg::*;
#(
  parameter logic [7:0] PORT_NUMBER = 8'h00,
  parameter bit WIDE_DATA = 1'b0,
  parameter bit PACKED = 1'b1,
  parameter int COMPONENTS = 2,
  parameter logic [31:0] COMPONENT_BASE = 32'h8000_0000,
  parameter logic [31:0] DIRECTORY_BASE = 32'hc000_0000,
  // Arbitrary neutral value, not a registered designer code
  parameter logic [31:0] IDENT_VALUE = 32'h1001_0a01
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] port_select_field,
  input wire logic [3:0] register_bank_select,
  input wire logic [1:0] req_reg_index,
  input wire logic req_write,
  input wire logic [31:0] req_wdata,
  output logic resp_valid,
  input wire logic resp_ready,
  output logic [31:0] resp_rdata,
  output logic resp_error,
  input wire logic abort,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic [2:0] mem_size,
  output logic mem_barrier,
  output logic [31:0] mem_wdata,
  output logic [31:0] mem_wdata_hi,
  input wire logic mem_resp_valid,
  output logic mem_resp_ready,
  input wire logic [31:0] mem_resp_rdata,
  input wire logic [31:0] mem_resp_rdata_hi,
  input wire logic mem_resp_error
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_RESP, ST_FLUSH} state_t;

  state_t state_r;
  logic [2:0] size_r;
  logic [1:0] inc_r;
  logic [31:0] transfer_address_r;
  logic [7:0] xfer_count_r;
  logic cur_write_r;
  logic cur_banked_r;
  logic cur_window_r;
  logic cur_barrier_r;
  logic [1:0] cur_index_r;
  logic [11:0] beats_left_r;
  logic [31:0] acc_r;
  logic [31:0] hold_r;
  logic wide_half_r;
  logic [31:0] cur_lo_r;
  logic [31:0] cur_hi_r;
  logic [31:0] resp_rdata_r;
  logic resp_error_r;

  stream_if #(.WIDTH(RESP_FIFO_WIDTH)) resp_in ();
  stream_if #(.WIDTH(RESP_FIFO_WIDTH)) resp_out ();

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic take;
  logic hit;
  logic [7:0] reg_off;
  logic is_window;
  logic is_banked;
  logic is_barrier;
  logic is_data;
  logic wide_mode;
  logic wide_skip;
  logic packed_mode;
  logic [2:0] beats_per;
  logic [11:0] seq_len;
  logic starts_mem;
  logic [31:0] base_value;
  logic [31:0] reg_rdata;
  logic [1:0] inc_view;

  assign req_ready = (state_r == ST_IDLE);
  assign take = req_valid && req_ready;
  assign hit = (port_select_field == PORT_NUMBER); // R20
  assign reg_off = {register_bank_select, req_reg_index, 2'b00}; // R20 R21
  assign is_window = (reg_off == OFF_DATA_WINDOW);
  assign is_banked = (reg_off[7:4] == OFF_BANKED_BASE[7:4]);
  assign is_barrier = (reg_off == OFF_BARRIER); // R07
  assign is_data = is_window || is_banked;
  assign wide_mode = WIDE_DATA && (size_r == SIZE_DWORD);
  // Lower word is the first access; a write's first half and a read's second half complete locally
  assign wide_skip = wide_mode && is_data && (req_write ^ wide_half_r) && !wide_half_r
    ? req_write : (wide_mode && is_data && wide_half_r && !req_write); // R08
  assign packed_mode = PACKED && (inc_r == INC_PACKED) && (size_r < SIZE_WORD);
  assign beats_per = (packed_mode && is_window)
    ? ((size_r == SIZE_BYTE) ? 3'h4 : 3'h2) : 3'h1; // R10
  assign seq_len = is_barrier ? 12'h001
    : 12'(12'(beats_per) * (12'(xfer_count_r) + 12'h001)); // R09
  assign starts_mem = hit && (is_data || is_barrier) && !wide_skip; // R01
  assign inc_view = (inc_r == INC_PACKED && !PACKED) ? INC_OFF : inc_r;
  // Several components need the directory table
  assign base_value = ((COMPONENTS > 1) ? DIRECTORY_BASE : COMPONENT_BASE)
    & ~(GRANULE_BYTES - 32'h1); // R15 R16 R17 R19

  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (!hit) begin
      reg_rdata = 32'h0000_0000;
    end else if (reg_off == OFF_CONTROL_STATUS) begin
      reg_rdata[CSW_SIZE_LSB +: 3] = size_r;
      reg_rdata[CSW_INC_LSB +: 2] = inc_view;
    end else if (reg_off == OFF_TRANSFER_ADDR) begin
      reg_rdata = transfer_address_r;
    end else if (reg_off == OFF_XFER_COUNT) begin
      reg_rdata[7:0] = xfer_count_r;
    end else if (reg_off == OFF_CONFIG) begin
      reg_rdata[CFG_WIDE_BIT] = WIDE_DATA;
      reg_rdata[CFG_PACKED_BIT] = PACKED;
    end else if (reg_off == OFF_DEBUG_BASE) begin
      reg_rdata = base_value; // R19
    end else if (reg_off == OFF_IDENT) begin
      reg_rdata = IDENT_VALUE; // R14
    end else if (is_data && wide_skip) begin
      reg_rdata = hold_r; // R08
    end
  end

  // ----------------------------------------------------------------
  // Memory side
  // ----------------------------------------------------------------
  logic mem_fire;
  logic pop;
  logic beat_error;
  logic [31:0] lane_mask;
  logic [31:0] step;

  mem_addr_former addr_former (
    .transfer_address(transfer_address_r),
    .banked(cur_banked_r),
    .bank_index(cur_index_r),
    .mem_addr(mem_addr)
  );

  // One beat in flight at a time keeps beats strictly in order
  assign mem_req_valid = (state_r == ST_ISSUE); // R23
  assign mem_fire = mem_req_valid && mem_req_ready;
  assign mem_write = cur_write_r;
  assign mem_barrier = cur_barrier_r;
  assign mem_size = wide_mode ? SIZE_DWORD : (packed_mode && cur_window_r) ? size_r : SIZE_WORD;
  assign mem_wdata = cur_lo_r;
  assign mem_wdata_hi = cur_hi_r;

  assign resp_in.valid = mem_resp_valid;
  assign resp_in.data = {mem_resp_error, mem_resp_rdata_hi, mem_resp_rdata};
  assign mem_resp_ready = resp_in.ready;
  // Drained only in wait and flush; one beat in flight keeps the buffer from filling
  assign resp_out.ready = (state_r == ST_WAIT) || (state_r == ST_FLUSH);
  assign pop = resp_out.valid && resp_out.ready;
  assign beat_error = resp_out.data[64];

  resp_fifo #(.WIDTH(RESP_FIFO_WIDTH), .DEPTH(RESP_FIFO_DEPTH)) resp_buffer (
    .clock(clock),
    .reset_n(reset_n),
    .wr(resp_in),
    .rd(resp_out)
  );

  always_comb begin
    lane_mask = 32'hffff_ffff;
    if (mem_size == SIZE_BYTE) begin
      lane_mask = 32'h0000_00ff << {mem_addr[1:0], 3'b000};
    end else if (mem_size == SIZE_HALF) begin
      lane_mask = 32'h0000_ffff << {mem_addr[1], 4'h0};
    end
  end

  assign step = 32'h0000_0001 << mem_size;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= starts_mem ? ST_ISSUE : ST_RESP; // R01
          end
        end
        ST_ISSUE: begin
          if (abort) begin
            state_r <= mem_fire ? ST_FLUSH : ST_IDLE; // R13
          end else if (mem_fire) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (abort) begin
            state_r <= pop ? ST_IDLE : ST_FLUSH; // R13
          end else if (pop) begin
            if (beat_error || beats_left_r == 12'h001) begin
              state_r <= ST_RESP; // R11 R12
            end else begin
              state_r <= ST_ISSUE; // R09 R10
            end
          end
        end
        ST_RESP: begin
          if (abort || resp_ready) begin
            state_r <= ST_IDLE;
          end
        end
        ST_FLUSH: begin
          // An issued beat lands and is thrown away
          if (pop) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Programmable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      size_r <= SIZE_RESET;
      inc_r <= INC_RESET;
      xfer_count_r <= XFER_COUNT_RESET;
    end else if (take && hit && req_write) begin
      if (reg_off == OFF_CONTROL_STATUS) begin
        size_r <= req_wdata[CSW_SIZE_LSB +: 3];
        inc_r <= req_wdata[CSW_INC_LSB +: 2];
      end else if (reg_off == OFF_XFER_COUNT) begin
        xfer_count_r <= req_wdata[7:0];
      end
    end
  end

  // Address advances only after a successful window beat
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      transfer_address_r <= TRANSFER_ADDR_RESET;
    end else if (take && hit && req_write && reg_off == OFF_TRANSFER_ADDR) begin
      transfer_address_r <= req_wdata;
    end else if (state_r == ST_WAIT && pop && !abort && !beat_error && cur_window_r
        && inc_view != INC_OFF) begin
      transfer_address_r <= transfer_address_r + step;
    end
  end

  // ----------------------------------------------------------------
  // Current request and data assembly
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur_write_r <= 1'b0;
      cur_banked_r <= 1'b0;
      cur_window_r <= 1'b0;
      cur_barrier_r <= 1'b0;
      cur_index_r <= 2'h0;
      cur_lo_r <= 32'h0000_0000;
      cur_hi_r <= 32'h0000_0000;
    end else if (take) begin
      cur_write_r <= req_write; // R21
      cur_banked_r <= is_banked;
      cur_window_r <= is_window;
      cur_barrier_r <= is_barrier;
      cur_index_r <= req_reg_index;
      cur_lo_r <= (wide_mode && is_data && req_write) ? hold_r : req_wdata;
      cur_hi_r <= req_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      beats_left_r <= 12'h000;
      acc_r <= 32'h0000_0000;
    end else if (take) begin
      beats_left_r <= seq_len;
      acc_r <= 32'h0000_0000;
    end else if (state_r == ST_WAIT && pop) begin
      beats_left_r <= beats_left_r - 12'h001;
      acc_r <= (acc_r & ~lane_mask) | (resp_out.data[31:0] & lane_mask); // R03 R10
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 32'h0000_0000;
      wide_half_r <= 1'b0;
    end else if (take && hit && req_write && reg_off == OFF_CONTROL_STATUS) begin
      wide_half_r <= 1'b0;
    end else if (take && wide_mode && is_data && hit && wide_skip) begin
      hold_r <= req_wdata;
      wide_half_r <= ~wide_half_r; // R08
    end else if (state_r == ST_WAIT && pop && wide_mode && cur_banked_r | cur_window_r) begin
      hold_r <= resp_out.data[63:32];
      wide_half_r <= !(beat_error || abort) && !cur_write_r;
    end
  end

  // ----------------------------------------------------------------
  // Answer to the debug port
  // ----------------------------------------------------------------
  assign resp_valid = (state_r == ST_RESP); // R22
  assign resp_rdata = resp_rdata_r;
  assign resp_error = resp_error_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resp_rdata_r <= 32'h0000_0000;
      resp_error_r <= 1'b0;
    end else if (take) begin
      resp_rdata_r <= reg_rdata;
      resp_error_r <= 1'b0;
    end else if (state_r == ST_WAIT && pop) begin
      resp_error_r <= beat_error; // R12
      resp_rdata_r <= (acc_r & ~lane_mask) | (resp_out.data[31:0] & lane_mask); // R03
    end
  end

endmodule : mem_port_dispatch

`default_nettype wire

// ---- verilog/mem_port_pkg.sv ----
// Constants shared by the debug memory access port dispatch block
package mem_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the access port register space
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] OFF_TRANSFER_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA_WINDOW = 8'h0c;
  localparam logic [7:0] OFF_BANKED_BASE = 8'h10;
  localparam logic [7:0] OFF_BARRIER = 8'h20;
  localparam logic [7:0] OFF_XFER_COUNT = 8'h24;
  localparam logic [7:0] OFF_CONFIG = 8'hf4;
  localparam logic [7:0] OFF_DEBUG_BASE = 8'hf8;
  localparam logic [7:0] OFF_IDENT = 8'hfc;

  // ----------------------------------------------------------------
  // Control/status word fields and reset values
  // ----------------------------------------------------------------
  localparam int CSW_SIZE_LSB = 0;
  localparam int CSW_INC_LSB = 4;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;
  localparam logic [1:0] INC_OFF = 2'h0;
  localparam logic [1:0] INC_SINGLE = 2'h1;
  localparam logic [1:0] INC_PACKED = 2'h2;
  localparam logic [2:0] SIZE_RESET = 3'h2;
  localparam logic [1:0] INC_RESET = 2'h0;
  localparam logic [31:0] TRANSFER_ADDR_RESET = 32'h0000_0000;
  localparam logic [7:0] XFER_COUNT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_WIDE_BIT = 2;
  localparam int CFG_PACKED_BIT = 3;

  // ----------------------------------------------------------------
  // Connected address space layout
  // ----------------------------------------------------------------
  localparam logic [31:0] BLOCK_BYTES = 32'h0000_1000;
  localparam logic [31:0] GRANULE_BYTES = 32'h0001_0000;

  // ----------------------------------------------------------------
  // Response buffer shape
  // ----------------------------------------------------------------
  localparam int RESP_FIFO_DEPTH = 16;
  localparam int RESP_FIFO_WIDTH = 65;

endpackage : mem_port_pkg

// ---- verilog/resp_fifo.sv ----
// Synchronous FIFO holding memory responses on their way to the dispatcher
`timescale 1ns/10ps
`default_nettype none

module resp_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  stream_if.consumer wr,
  stream_if.producer rd
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0] count_r;
  logic push;
  logic pop;

  assign wr.ready = (count_r != (PTR_W+1)'(DEPTH));
  assign rd.valid = (count_r != '0);
  assign rd.data = mem[rd_ptr_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= wr.data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : resp_fifo

`default_nettype wire

// ---- verilog/stream_if.sv ----
// Valid/ready word stream carrier between the dispatcher and its buffer
`timescale 1ns/10ps
`default_nettype none

interface stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire
